// ---- verilog/ecr_consts.svh ----
// Constants for the exception cause register block
`ifndef ECR_CONSTS_SVH
`define ECR_CONSTS_SVH

// ***********************************
// Register offsets (word index times four)
// ***********************************
`define ECR_OFF_CAUSE 8'h00
`define ECR_OFF_RESUME 8'h04
`define ECR_OFF_STATUS 8'h08
`define ECR_OFF_MASK 8'h0C

// ***********************************
// Cause register field positions
// ***********************************
`define ECR_BIT_DELAY 31
`define ECR_CU_HI 29
`define ECR_CU_LO 28
`define ECR_IP_HI 15
`define ECR_IP_LO 8
`define ECR_SWIP_HI 9
`define ECR_HWIP_LO 10
`define ECR_CODE_HI 5
`define ECR_CODE_LO 2
`define ECR_CAUSE_RESET 32'h0000_0000
`define ECR_RESUME_RESET 32'h0000_0000

// ***********************************
// Cause codes
// ***********************************
`define ECR_CODE_INT 4'h0
`define ECR_CODE_MOD 4'h1
`define ECR_CODE_TLB_LOAD 4'h2
`define ECR_CODE_TLB_STORE 4'h3
`define ECR_CODE_ADDR_LOAD 4'h4
`define ECR_CODE_ADDR_STORE 4'h5
`define ECR_CODE_BUS_FETCH 4'h6
`define ECR_CODE_BUS_DATA 4'h7
`define ECR_CODE_SYSCALL 4'h8
`define ECR_CODE_BREAK 4'h9
`define ECR_CODE_BAD_OP 4'hA
`define ECR_CODE_COP 4'hB
`define ECR_CODE_WRAP 4'hC

// ***********************************
// Interrupt status bits
// ***********************************
`define ECR_IRQ_EXC 0
`define ECR_IRQ_PEND 1
`define ECR_IRQ_RESERVED 2
`define ECR_IRQ_W 3

`endif

// ---- verilog/ecr_pkg.sv ----
// Types for the exception cause register block
package ecr_pkg;

	// Exception kinds raised by the pipeline
	typedef enum logic [3:0] {
		ECR_EXC_INT = 4'h0,
		ECR_EXC_MOD = 4'h1,
		ECR_EXC_TLB_LOAD = 4'h2,
		ECR_EXC_TLB_STORE = 4'h3,
		ECR_EXC_ADDR_LOAD = 4'h4,
		ECR_EXC_ADDR_STORE = 4'h5,
		ECR_EXC_BUS_FETCH = 4'h6,
		ECR_EXC_BUS_DATA = 4'h7,
		ECR_EXC_SYSCALL = 4'h8,
		ECR_EXC_BREAK = 4'h9,
		ECR_EXC_BAD_OP = 4'hA,
		ECR_EXC_COP = 4'hB,
		ECR_EXC_WRAP = 4'hC,
		ECR_EXC_RSVD = 4'hF
	} ecr_exc_kind_t;

	// One exception report from the pipeline
	typedef struct packed {
		logic valid;
		ecr_exc_kind_t kind;
		logic in_delay_slot;
		logic [1:0] cop_num;
		logic [31:0] fault_pc;
		logic [31:0] branch_pc;
	} ecr_exc_req_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} ecr_bus_req_t;

	// Latch state
	typedef enum logic [1:0] {
		ECR_ST_IDLE = 2'b01,
		ECR_ST_HOLD = 2'b10
	} ecr_state_t;

endpackage

// ---- verilog/ecr_sync.sv ----
// Two-flop synchroniser for the interrupt pins
`timescale 1ns/10ps
module ecr_sync #(
	parameter int WIDTH = 6
) (
	input wire logic core_clk_i, // Core clock
	input wire logic rst_i, // Synchronous reset
	input wire logic [WIDTH-1:0] async_i, // Unsynchronised levels
	output logic [WIDTH-1:0] sync_o // Synchronised levels
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_stage2;

	always_comb begin
		next_stage1 = async_i;
		next_stage2 = stage1;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign sync_o = stage2;
endmodule

// ---- verilog/ecr_code_map.sv ----
// Maps an exception kind onto the cause code field
`timescale 1ns/10ps
`include "ecr_consts.svh"
module ecr_code_map (
	input ecr_pkg::ecr_exc_kind_t kind_i, // Exception kind
	output logic [3:0] code_o, // Cause code
	output logic known_o // Kind has a defined code
);
	always_comb begin
		known_o = 1'b1;
		case (kind_i)
			ecr_pkg::ECR_EXC_INT: code_o = `ECR_CODE_INT;
			ecr_pkg::ECR_EXC_MOD: code_o = `ECR_CODE_MOD;
			ecr_pkg::ECR_EXC_TLB_LOAD: code_o = `ECR_CODE_TLB_LOAD;
			ecr_pkg::ECR_EXC_TLB_STORE: code_o = `ECR_CODE_TLB_STORE;
			ecr_pkg::ECR_EXC_ADDR_LOAD: code_o = `ECR_CODE_ADDR_LOAD;
			ecr_pkg::ECR_EXC_ADDR_STORE: code_o = `ECR_CODE_ADDR_STORE;
			ecr_pkg::ECR_EXC_BUS_FETCH: code_o = `ECR_CODE_BUS_FETCH;
			ecr_pkg::ECR_EXC_BUS_DATA: code_o = `ECR_CODE_BUS_DATA;
			ecr_pkg::ECR_EXC_SYSCALL: code_o = `ECR_CODE_SYSCALL;
			ecr_pkg::ECR_EXC_BREAK: code_o = `ECR_CODE_BREAK;
			ecr_pkg::ECR_EXC_BAD_OP: code_o = `ECR_CODE_BAD_OP;
			ecr_pkg::ECR_EXC_COP: code_o = `ECR_CODE_COP;
			ecr_pkg::ECR_EXC_WRAP: code_o = `ECR_CODE_WRAP;
			default: begin
				code_o = `ECR_CODE_INT;
				known_o = 1'b0;
			end
		endcase
	end
endmodule

// ---- verilog/ecr_cause_reg.sv ----
// Exception cause register with resume address and interrupt status
`timescale 1ns/10ps
`include "ecr_consts.svh"
// Overview of operation
// - A 32-bit readable, writable register describes the last exception.
// - Each exception writes a 4-bit cause code.
// - Delay slot flag is 1 for a delay slot exception, else 0.
// - Coprocessor unusable loads the referenced coprocessor number.
// - Pending bits 1..0 are software writable interrupt requests.
// - Pending bits 7..2 are read only and follow interrupt sources.
// - Six external interrupt inputs; pending bit 5 is the FPU interrupt.
// - Unused bits ignore writes and read zero.
// - Codes: protected write 1, miss load 2, miss store 3.
// - Codes: address error load 4, store 5.
// - Codes: bus error fetch 6, data 7.
// - Codes: interrupt 0, syscall 8 to overflow 12; 13-15 reserved.
// - In a delay slot the resume address is the preceding branch.
module ecr_cause_reg #(
	parameter int HW_IRQS = 6
) (
	input wire logic core_clk_i, // Core clock, 10 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [HW_IRQS-1:0] hw_irq_i, // External interrupt pins
	input ecr_pkg::ecr_exc_req_t exc_i, // Exception report from pipeline
	input wire logic [7:0] bus_addr_i, // Register byte address
	input wire logic [31:0] bus_wdata_i, // Write data
	input wire logic bus_wr_i, // Write strobe
	input wire logic bus_rd_i, // Read strobe
	output logic [31:0] bus_rdata_o, // Read data, cycle after strobe
	output logic [7:0] pending_irq_bits_o, // Live pending bits
	output logic [31:0] resume_address_o, // Resume address
	output logic irq_o // Block interrupt, level
);

	// ***********************************
	// Interrupt inputs
	// ***********************************
	logic [HW_IRQS-1:0] hw_irq_sync;

	ecr_sync #(
		.WIDTH(HW_IRQS)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(hw_irq_i),
		.sync_o(hw_irq_sync)
	);

	// ***********************************
	// Cause code mapping
	// ***********************************
	logic [3:0] mapped_code;
	logic code_known;

	ecr_code_map u_map (
		.kind_i(exc_i.kind),
		.code_o(mapped_code),
		.known_o(code_known)
	);

	// ***********************************
	// Register state
	// ***********************************
	logic delay_slot_flag;
	logic [1:0] cop_unit;
	logic [1:0] sw_irq;
	logic [3:0] cause_code_field;
	logic [31:0] resume_address;
	logic [`ECR_IRQ_W-1:0] irq_status;
	logic [`ECR_IRQ_W-1:0] irq_mask;
	logic [31:0] rdata;
	ecr_pkg::ecr_state_t state;

	logic next_delay_slot_flag;
	logic [1:0] next_cop_unit;
	logic [1:0] next_sw_irq;
	logic [3:0] next_cause_code_field;
	logic [31:0] next_resume_address;
	logic [`ECR_IRQ_W-1:0] next_irq_status;
	logic [`ECR_IRQ_W-1:0] next_irq_mask;
	logic [31:0] next_rdata;
	ecr_pkg::ecr_state_t next_state;

	logic [7:0] pending_irq_bits;
	logic [31:0] cause_word;
	logic [`ECR_IRQ_W-1:0] irq_events;
	logic wr_cause;
	logic wr_resume;
	logic wr_status;
	logic wr_mask;
	logic [7:0] pend_prev;

	// Builds the architectural view of the cause register
	function automatic logic [31:0] pack_cause(input logic bd, input logic [1:0] cu, input logic [7:0] ip,
		input logic [3:0] code);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`ECR_BIT_DELAY] = bd;
		w[`ECR_CU_HI:`ECR_CU_LO] = cu;
		w[`ECR_IP_HI:`ECR_IP_LO] = ip;
		w[`ECR_CODE_HI:`ECR_CODE_LO] = code;
		return w;
	endfunction

	// pin 0 lands on pending bit 2
	always_comb begin
		pending_irq_bits = {hw_irq_sync, sw_irq};
	end

	always_comb begin
		cause_word = pack_cause(delay_slot_flag, cop_unit, pending_irq_bits, cause_code_field);
	end

	always_comb begin
		wr_cause = bus_wr_i && (bus_addr_i == `ECR_OFF_CAUSE);
		wr_resume = bus_wr_i && (bus_addr_i == `ECR_OFF_RESUME);
		wr_status = bus_wr_i && (bus_addr_i == `ECR_OFF_STATUS);
		wr_mask = bus_wr_i && (bus_addr_i == `ECR_OFF_MASK);
	end

	// ***********************************
	// Exception capture
	// ***********************************
	// A pipeline exception outranks a software write of the code, delay flag, resume address and (for COP) unit in the same cycle,
	// since losing a real fault report is worse than losing a rewrite.
	always_comb begin
		next_delay_slot_flag = delay_slot_flag;
		next_cop_unit = cop_unit;
		next_sw_irq = sw_irq;
		next_cause_code_field = cause_code_field;
		next_resume_address = resume_address;
		next_state = state;
		if (wr_cause) begin
			next_sw_irq = bus_wdata_i[`ECR_SWIP_HI:`ECR_IP_LO];
		end
		if (wr_cause) begin
			next_delay_slot_flag = bus_wdata_i[`ECR_BIT_DELAY];
			next_cop_unit = bus_wdata_i[`ECR_CU_HI:`ECR_CU_LO];
			next_cause_code_field = bus_wdata_i[`ECR_CODE_HI:`ECR_CODE_LO];
		end
		if (wr_resume) begin
			next_resume_address = bus_wdata_i;
		end
		case (state)
			ecr_pkg::ECR_ST_IDLE: begin
				if (exc_i.valid) begin
					next_state = ecr_pkg::ECR_ST_HOLD;
				end
			end
			ecr_pkg::ECR_ST_HOLD: begin
				if (!exc_i.valid) begin
					next_state = ecr_pkg::ECR_ST_IDLE;
				end
			end
			default: begin
				next_state = ecr_pkg::ECR_ST_IDLE;
			end
		endcase
		if (exc_i.valid) begin
			next_cause_code_field = mapped_code;
			next_delay_slot_flag = exc_i.in_delay_slot;
			if (exc_i.kind == ecr_pkg::ECR_EXC_COP) begin
				next_cop_unit = exc_i.cop_num;
			end
			if (exc_i.in_delay_slot) begin
				next_resume_address = exc_i.branch_pc;
			end else begin
				next_resume_address = exc_i.fault_pc;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			delay_slot_flag <= 1'b0;
			cop_unit <= 2'h0;
			sw_irq <= 2'h0;
			cause_code_field <= 4'h0;
			resume_address <= `ECR_RESUME_RESET;
			state <= ecr_pkg::ECR_ST_IDLE;
		end else begin
			delay_slot_flag <= next_delay_slot_flag;
			cop_unit <= next_cop_unit;
			sw_irq <= next_sw_irq;
			cause_code_field <= next_cause_code_field;
			resume_address <= next_resume_address;
			state <= next_state;
		end
	end

	// ***********************************
	// Interrupt status and mask
	// ***********************************
	always_comb begin
		irq_events = '0;
		irq_events[`ECR_IRQ_EXC] = exc_i.valid && (state == ecr_pkg::ECR_ST_IDLE);
		irq_events[`ECR_IRQ_PEND] = |(pending_irq_bits & ~pend_prev);
		irq_events[`ECR_IRQ_RESERVED] = exc_i.valid && !code_known;
	end

	// Set wins over a write-one-to-clear in the same cycle
	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask = irq_mask;
		if (wr_status) begin
			next_irq_status = irq_status & ~bus_wdata_i[`ECR_IRQ_W-1:0];
		end
		next_irq_status = next_irq_status | irq_events;
		if (wr_mask) begin
			next_irq_mask = bus_wdata_i[`ECR_IRQ_W-1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			irq_status <= '0;
			irq_mask <= '0;
			pend_prev <= 8'h00;
		end else begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			pend_prev <= pending_irq_bits;
		end
	end

	// ***********************************
	// Read port
	// ***********************************
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (bus_rd_i) begin
			case (bus_addr_i)
				`ECR_OFF_CAUSE: next_rdata = cause_word;
				`ECR_OFF_RESUME: next_rdata = resume_address;
				`ECR_OFF_STATUS: next_rdata = {29'h0, irq_status};
				`ECR_OFF_MASK: next_rdata = {29'h0, irq_mask};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign bus_rdata_o = rdata;
	assign pending_irq_bits_o = pending_irq_bits;
	assign resume_address_o = resume_address;
	assign irq_o = |(irq_status & irq_mask);

endmodule

// ---- dv/ecr_pipe_model.sv ----
// Pipeline exception source that faces the cause register
`timescale 1ns/10ps
module ecr_pipe_model (
	input wire logic core_clk_i, // Core clock
	input wire logic rst_i, // Synchronous reset
	input wire logic go_i, // Raise one exception
	input wire logic [3:0] kind_i, // Exception kind
	input wire logic slot_i, // Faulting op in a delay slot
	input wire logic [1:0] cop_i, // Coprocessor referenced
	input wire logic [31:0] pc_i, // Faulting address
	output ecr_pkg::ecr_exc_req_t exc_o // Report to the register
);
	ecr_pkg::ecr_exc_req_t next_exc;

	// Idle address fields toggle so a stale value is never mistaken for a report
	always_comb begin
		next_exc = exc_o;
		next_exc.valid = go_i;
		next_exc.fault_pc = ~exc_o.fault_pc;
		next_exc.branch_pc = ~exc_o.branch_pc;
		if (go_i) begin
			next_exc.kind = ecr_pkg::ecr_exc_kind_t'(kind_i);
			next_exc.in_delay_slot = slot_i;
			next_exc.cop_num = cop_i;
			next_exc.fault_pc = pc_i;
			next_exc.branch_pc = pc_i - 32'h4;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			exc_o <= '0;
		end else begin
			exc_o <= next_exc;
		end
	end
endmodule

// ---- dv/ecr_cause_reg_sva.sv ----
// Port assertions for the exception cause register
`timescale 1ns/10ps
module ecr_cause_reg_sva #(
	parameter int HW_IRQS = 6
) (
	input wire logic core_clk_i, // Core clock
	input wire logic rst_i, // Reset
	input wire logic [HW_IRQS-1:0] hw_irq_i, // Interrupt pins
	input ecr_pkg::ecr_exc_req_t exc_i, // Exception report
	input wire logic [7:0] bus_addr_i, // Address
	input wire logic [31:0] bus_wdata_i, // Write data
	input wire logic bus_wr_i, // Write strobe
	input wire logic bus_rd_i, // Read strobe
	input wire logic [31:0] bus_rdata_o, // Read data
	input wire logic [7:0] pending_irq_bits_o, // Pending bits
	input wire logic [31:0] resume_address_o, // Resume address
	input wire logic irq_o // Interrupt
);
	logic [1:0] sw_wdata;
	assign sw_wdata = bus_wdata_i[9:8];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence exc_then_read;
		exc_i.valid ##1 (bus_rd_i && bus_addr_i == 8'h00 && !exc_i.valid);
	endsequence
	sequence cop_then_read;
		exc_i.valid && exc_i.kind == ecr_pkg::ECR_EXC_COP ##1 (bus_rd_i && bus_addr_i == 8'h00);
	endsequence

	a_code_loaded: assert property (exc_then_read |=>
		bus_rdata_o[5:2] == (($past(exc_i.kind, 2) > 4'hC) ? 4'h0 : $past(exc_i.kind, 2))) else $error("bad cause code");
	a_delay_flag: assert property (exc_then_read |=>
		bus_rdata_o[31] == $past(exc_i.in_delay_slot, 2)) else $error("bad delay flag");
	a_cop_number: assert property (cop_then_read |=>
		bus_rdata_o[29:28] == $past(exc_i.cop_num, 2)) else $error("bad coprocessor number");
	a_resume_addr: assert property (exc_i.valid |=>
		resume_address_o == ($past(exc_i.in_delay_slot) ? $past(exc_i.branch_pc) : $past(exc_i.fault_pc)))
		else $error("bad resume address");
	a_unused_zero: assert property (bus_rd_i && bus_addr_i == 8'h00 |=>
		(bus_rdata_o & 32'h4FFF_00C3) == 32'h0) else $error("unused bit set");
	a_sw_bits: assert property (bus_wr_i && bus_addr_i == 8'h00 |=>
		pending_irq_bits_o[1:0] == $past(sw_wdata)) else $error("software bits wrong");
	a_hw_follow: assert property ($stable(hw_irq_i) [*3] |->
		pending_irq_bits_o[7:2] == hw_irq_i) else $error("hardware bits wrong");
	a_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == 32'h0) else $error("read data without read");
endmodule

bind ecr_cause_reg ecr_cause_reg_sva #(.HW_IRQS(HW_IRQS)) ecr_cause_reg_sva_i (.core_clk_i, .rst_i, .hw_irq_i,
	.exc_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o, .pending_irq_bits_o,
	.resume_address_o, .irq_o);

// ---- dv/testbench.sv ----
// Self-checking bench for the exception cause register
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [5:0] hw_irq_i = 6'h00;
	logic [7:0] bus_addr_i = 8'h00;
	logic [31:0] bus_wdata_i = 32'h0;
	logic bus_wr_i = 1'b0;
	logic bus_rd_i = 1'b0;
	logic go = 1'b0;
	logic [3:0] kind = 4'h0;
	logic slot = 1'b0;
	logic [1:0] cop = 2'h0;
	logic [31:0] pc = 32'h0;
	ecr_pkg::ecr_exc_req_t exc;
	logic [31:0] bus_rdata_o;
	logic [31:0] resume_address_o;
	logic [7:0] pending_irq_bits_o;
	logic irq_o;
	int mismatches = 0;
	int comparisons = 0;
	int seed = 32'h6C9B;
	logic [31:0] d;
	int m_bd = 0, m_cop = 0, m_code = 0, m_sw = 0, m_resume = 0, m_status = 0, m_mask = 0;

	ecr_cause_reg #(.HW_IRQS(6)) ecr_cause_reg_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .hw_irq_i(hw_irq_i),
		.exc_i(exc), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
		.bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .pending_irq_bits_o(pending_irq_bits_o),
		.resume_address_o(resume_address_o), .irq_o(irq_o));
	ecr_pipe_model ecr_pipe_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go), .kind_i(kind),
		.slot_i(slot), .cop_i(cop), .pc_i(pc), .exc_o(exc));

	initial begin
		forever #50 core_clk_i = ~core_clk_i;
	end

	// ***********************************
	// Bus tasks and reference model
	// ***********************************
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		bus_addr_i <= a;
		bus_wdata_i <= v;
		bus_wr_i <= 1'b1;
		@(posedge core_clk_i);
		bus_wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge core_clk_i);
		bus_addr_i <= a;
		bus_rd_i <= 1'b1;
		@(posedge core_clk_i);
		bus_rd_i <= 1'b0;
		#1;
		`CHK(bus_rdata_o & m, e)
	endtask

	function automatic logic [31:0] cause_exp();
		return (m_bd << 31) | (m_cop << 28) | (hw_irq_i << 10) | (m_sw << 8) | (m_code << 2);
	endfunction

	// Raise one exception, read it back, then clear its status
	task automatic raise(input int k);
		logic s;
		logic [1:0] c;
		logic [31:0] p;
		s = 1'($random(seed));
		c = 2'($random(seed));
		p = $random(seed);
		@(posedge core_clk_i);
		go <= 1'b1;
		kind <= k[3:0];
		slot <= s;
		cop <= c;
		pc <= p;
		@(posedge core_clk_i);
		go <= 1'b0;
		m_code = (k > 12) ? 0 : k;
		m_bd = s;
		m_cop = (k == 11) ? c : m_cop;
		m_resume = s ? p - 32'h4 : p;
		m_status = m_status | 1 | ((k > 12) ? 4 : 0);
		rd_chk(8'h00, cause_exp(), 32'hFFFF_FFFF);
		`CHK(resume_address_o, m_resume)
		`CHK(irq_o, 1'b1)
		rd_chk(8'h08, m_status, 32'h5);
		wr(8'h08, 32'h7);
		m_status = 0;
		`CHK(irq_o, 1'b0)
	endtask

	task automatic wrap_up();
		$display("Counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge core_clk_i);
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd_chk(8'h00, 32'h0, 32'hFFFF_FFFF);
		rd_chk(8'h04, 32'h0, 32'hFFFF_FFFF);
		$display("test reset done");
		wr(8'h0C, 32'h5);
		m_mask = 5;
		rd_chk(8'h0C, m_mask, 32'h7);
		for (int k = 0; k < 16; k++) begin
			raise(k);
		end
		$display("test exceptions done");
		repeat (4) begin
			d = $random(seed);
			wr(8'h00, d);
			// A software bit going high counts as a rising pending bit
			m_status = ((d[9:8] & ~m_sw[1:0]) != 2'h0) ? 2 : 0;
			m_bd = d[31];
			m_cop = d[29:28];
			m_sw = d[9:8];
			m_code = d[5:2];
			`CHK(pending_irq_bits_o[1:0], d[9:8])
			rd_chk(8'h00, cause_exp(), 32'hFFFF_FFFF);
			rd_chk(8'h08, m_status, 32'h7);
			wr(8'h08, 32'h7);
			m_status = 0;
		end
		$display("test software bits done");
		repeat (4) begin
			@(posedge core_clk_i);
			hw_irq_i <= 6'($random(seed));
			repeat (3) @(posedge core_clk_i);
			#1;
			// pin 0 lands on pending bit 2
			`CHK(pending_irq_bits_o, {hw_irq_i, m_sw[1:0]})
			rd_chk(8'h00, cause_exp(), 32'hFFFF_FFFF);
		end
		$display("test hardware bits done");
		d = $random(seed);
		wr(8'h04, d);
		rd_chk(8'h04, d, 32'hFFFF_FFFF);
		wr(8'h10, d);
		rd_chk(8'h10, 32'h0, 32'hFFFF_FFFF);
		$display("test unmapped done");
		wrap_up();
	end
endmodule
